// ---- hdl/tocp_pkg.sv ----
// Package for the timer output compare and PWM block: register map, fields, constants.
package tocp_pkg;

  localparam int unsigned NUM_CHAN = 6;
  localparam int unsigned NUM_PAIR = 3;

  // Channel control word layout, word CTRL(x) at byte CTRL_BASE + 8*x.
  localparam logic [11:0] CTRL_BASE    = 12'h000;
  localparam logic [11:0] CMP_BASE     = 12'h004;
  localparam logic [11:0] CHAN_STRIDE  = 12'h008;
  localparam logic [11:0] MOD_OFFS     = 12'h030;
  localparam logic [11:0] CNT_OFFS     = 12'h034;
  localparam logic [11:0] TCTRL_OFFS   = 12'h038;

  localparam int unsigned FLD_MAX      = 0;
  localparam int unsigned FLD_TOV      = 1;
  localparam int unsigned FLD_ACT_LO   = 2;
  localparam int unsigned FLD_MODE_LO  = 4;
  localparam int unsigned FLD_IE       = 6;
  localparam int unsigned FLD_FLAG     = 7;
  localparam int unsigned FLD_OVF      = 7;
  localparam int unsigned FLD_STOP     = 5;
  localparam int unsigned FLD_CRST     = 4;

  localparam logic [1:0]  MODE_UNBUF   = 2'h1;
  localparam logic [1:0]  MODE_BUF     = 2'h2;
  localparam logic [1:0]  ACT_CLEAR    = 2'h2;
  localparam logic [1:0]  ACT_SET      = 2'h3;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h1;

  localparam logic [15:0] MOD_RESET    = 16'hFFFF;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  TCTRL_RESET  = 8'h20;

  typedef struct packed {
    logic       flag;
    logic       irq_en;
    logic [1:0] mode;
    logic [1:0] action;
    logic       tov;
    logic       max_duty;
  } tocp_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tocp_apb_req_t;

endpackage : tocp_pkg

// ---- hdl/tocp_top.sv ----
// Timer output compare and PWM generator with APB register slave.
`timescale 1ns/10ps
`default_nettype none

// Function
// RQ1: Unbuffered compare uses its register directly.
// RQ2: Compare fires only on counter equality.
// RQ3: Software lowers values in compare handler.
// RQ4: Compare match sets channel compare flag.
// RQ5: Software raises values in overflow handler.
// RQ6: Pair 0/1 buffered on channel 0 pin.
// RQ7: Last written register takes over at overflow.
// RQ8: Even control governs; odd pin released.
// RQ9: Pair 2/3 buffered on channel 2 pin.
// RQ10: Pair 4/5 buffered on channel 4 pin.
// RQ11: Software avoids writing the active register.
// RQ12: Pin toggles at counter overflow.
// RQ13: Width runs from overflow to compare.
// RQ14: Software picks clear or set action.
// RQ15: Modulo 255 gives 256 clock period.
// RQ16: Compare 128 of 256 gives half duty.
// RQ17: Shorter width written in compare handler.
// RQ18: Longer width written in overflow handler.
// RQ19: Software never toggles on compare in PWM.
// RQ20: Mode and action field encodings decoded.
// RQ21: Overflow on rollover after modulo match.
// RQ22: Zero duty without toggle; max forces full.
// RQ23: Buffer select beats unbuffered select.
// RQ24: Equality checked once per counter tick.
module tocp_top (
  input  wire logic                             mclk,       // 200 MHz clock
  input  wire logic                             reset_n,    // Async reset, low
  input  wire logic                             tick_en,    // Prescaled count enable
  input  wire logic                             psel,       // APB select
  input  wire logic                             penable,    // APB enable
  input  wire logic                             pwrite,     // APB write
  input  wire logic [11:0]                      paddr,      // APB byte address
  input  wire logic [31:0]                      pwdata,     // APB write data
  output logic      [31:0]                      prdata,     // APB read data
  output logic                                  pready,     // APB ready
  output logic                                  pslverr,    // APB error
  output logic      [tocp_pkg::NUM_CHAN-1:0]    chan_out,   // Channel output pins
  output logic      [tocp_pkg::NUM_CHAN-1:0]    chan_oe_n,  // Output enable, low drives
  output logic      [tocp_pkg::NUM_CHAN-1:0]    cmp_event,  // Compare match pulse
  output logic                                  ovf_event   // Overflow pulse
);
  import tocp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  function automatic logic buf_pair(input tocp_ctrl_t c);
    // RQ23 buffer priority
    buf_pair = c.mode[1];
  endfunction : buf_pair

  function automatic logic is_compare(input tocp_ctrl_t c);
    // RQ20 mode decode
    is_compare = (c.mode == MODE_UNBUF) || c.mode[1];
  endfunction : is_compare

  //////////////////////////////////////////////////////////////////////////////
  // State.

  tocp_ctrl_t  ctrl_r   [NUM_CHAN];
  tocp_ctrl_t  ctrl_nxt [NUM_CHAN];
  logic [15:0] cmp_r    [NUM_CHAN];
  logic [15:0] cmp_nxt  [NUM_CHAN];
  logic [NUM_CHAN-1:0] pin_r, pin_nxt;
  logic [NUM_PAIR-1:0] sel_odd_r, sel_odd_nxt;
  logic [NUM_PAIR-1:0] last_odd_r, last_odd_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] mod_r, mod_nxt;
  logic        ovf_r, ovf_nxt;
  logic        stop_r, stop_nxt;
  logic [31:0] prdata_nxt;
  logic [NUM_CHAN-1:0] match;
  logic        wrap;
  logic [15:0] cnt_inc;
  logic        run;
  tocp_apb_req_t req;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign pready  = 1'b1;
  assign run     = tick_en && !stop_r;
  // RQ21 rollover after modulo
  assign wrap    = run && (cnt_r == mod_r);
  assign ovf_event = wrap;

  // RQ13 RQ16 compare on reaching value
  // The compare looks at the value the counter is about to take, so the pin moves on the edge that brings
  // the count to the compare value, just as the overflow toggle lands on the edge that rolls it to zero.
  // A compare value of zero therefore coincides with the overflow toggle and gives no pulse at all.
  assign cnt_inc = (cnt_r == mod_r) ? 16'h0000 : cnt_r + 16'h0001;

  //////////////////////////////////////////////////////////////////////////////
  // Compare match: the even channel of a linked pair compares against the
  // register chosen by the pair selector; odd channels are idle then.

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_match
      logic [15:0] active_val;
      logic        linked_odd;
      if (g % 2 == 0) begin : g_even
        // RQ6 RQ9 RQ10 pair source
        assign active_val = (buf_pair(ctrl_r[g]) && sel_odd_r[g/2]) ? cmp_r[g+1] : cmp_r[g];
        assign linked_odd = 1'b0;
      end else begin : g_odd
        assign active_val = cmp_r[g];
        // RQ8 odd channel idle
        assign linked_odd = buf_pair(ctrl_r[g-1]);
      end
      // RQ1 RQ2 RQ24 equality compare
      assign match[g] = run && is_compare(ctrl_r[g]) && !linked_odd && (cnt_inc == active_val);
      assign cmp_event[g] = match[g];
      assign chan_out[g]  = pin_r[g];
      // RQ8 odd pin released
      assign chan_oe_n[g] = !(is_compare(ctrl_r[g]) && !linked_odd);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for counter, channels and bus.

  always_comb begin
    logic wr;
    logic rd;
    logic [11:0] a;
    wr = req.psel && req.penable && req.pwrite;
    rd = req.psel && !req.penable && !req.pwrite;
    a  = req.paddr;
    cnt_nxt      = cnt_r;
    mod_nxt      = mod_r;
    ovf_nxt      = ovf_r;
    stop_nxt     = stop_r;
    pin_nxt      = pin_r;
    sel_odd_nxt  = sel_odd_r;
    last_odd_nxt = last_odd_r;
    prdata_nxt   = prdata;
    pslverr      = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
      cmp_nxt[i]  = cmp_r[i];
    end

    // RQ15 RQ16 counter period is modulo plus one
    if (run) begin
      cnt_nxt = wrap ? 16'h0000 : cnt_r + 16'h0001;
    end

    // Bus writes first, so that hardware events below win over clears.
    if (wr) begin
      if (a == MOD_OFFS) begin
        mod_nxt = pwdata[15:0];
      end else if (a == TCTRL_OFFS) begin
        stop_nxt = pwdata[FLD_STOP];
        if (pwdata[FLD_CRST]) begin
          cnt_nxt = 16'h0000;
        end
        if (!pwdata[FLD_OVF]) begin
          ovf_nxt = 1'b0;
        end
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (a == CTRL_BASE + CHAN_STRIDE * 12'(i)) begin
          ctrl_nxt[i] = tocp_ctrl_t'(pwdata[7:0]);
          // A flag clears only when written as zero; the odd mode bit 1 is absent.
          ctrl_nxt[i].flag = ctrl_r[i].flag && pwdata[FLD_FLAG];
          if (i % 2 == 1) begin
            ctrl_nxt[i].mode[1] = 1'b0;
          end
        end
        if (a == CMP_BASE + CHAN_STRIDE * 12'(i)) begin
          cmp_nxt[i] = pwdata[15:0];
          // RQ7 last written tracking
          last_odd_nxt[i/2] = (i % 2 == 1);
        end
      end
    end

    if (wrap) begin
      ovf_nxt = 1'b1;
    end

    for (int i = 0; i < NUM_CHAN; i++) begin
      // RQ4 compare flag set
      if (match[i]) begin
        ctrl_nxt[i].flag = 1'b1;
      end
      if (i % 2 == 1 && buf_pair(ctrl_r[i-1])) begin
        pin_nxt[i] = pin_r[i];
      end else if (is_compare(ctrl_r[i])) begin
        // RQ12 toggle at overflow
        if (wrap && ctrl_r[i].tov) begin
          pin_nxt[i] = !pin_r[i];
        end
        // RQ13 RQ20 action at compare
        if (match[i]) begin
          case (ctrl_r[i].action)
            ACT_CLEAR:  pin_nxt[i] = 1'b0;
            ACT_SET:    pin_nxt[i] = 1'b1;
            ACT_TOGGLE: pin_nxt[i] = !pin_nxt[i];
            default:    pin_nxt[i] = pin_nxt[i];
          endcase
        end
        // RQ22 full duty force
        if (ctrl_r[i].max_duty && !ctrl_r[i].tov) begin
          pin_nxt[i] = 1'b1;
        end
      end
    end

    // RQ7 swap at overflow
    for (int p = 0; p < NUM_PAIR; p++) begin
      if (!buf_pair(ctrl_r[2*p])) begin
        sel_odd_nxt[p] = 1'b0;
      end else if (wrap) begin
        sel_odd_nxt[p] = last_odd_r[p];
      end
    end

    if (rd) begin
      prdata_nxt = 32'h0000_0000;
      if (a == MOD_OFFS) begin
        prdata_nxt[15:0] = mod_r;
      end else if (a == CNT_OFFS) begin
        prdata_nxt[15:0] = cnt_r;
      end else if (a == TCTRL_OFFS) begin
        prdata_nxt[FLD_OVF]  = ovf_r;
        prdata_nxt[FLD_STOP] = stop_r;
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (a == CTRL_BASE + CHAN_STRIDE * 12'(i)) begin
          prdata_nxt[7:0] = ctrl_r[i];
        end
        if (a == CMP_BASE + CHAN_STRIDE * 12'(i)) begin
          prdata_nxt[15:0] = cmp_r[i];
        end
      end
    end
    // Unmapped addresses answer zero without error, since software probes the map.
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r      <= 16'h0000;
      mod_r      <= MOD_RESET;
      ovf_r      <= 1'b0;
      stop_r     <= TCTRL_RESET[FLD_STOP];
      pin_r      <= '0;
      sel_odd_r  <= '0;
      last_odd_r <= '0;
      prdata     <= 32'h0000_0000;
      for (int i = 0; i < NUM_CHAN; i++) begin
        ctrl_r[i] <= tocp_ctrl_t'(CTRL_RESET);
        cmp_r[i]  <= 16'h0000;
      end
    end else begin
      cnt_r      <= cnt_nxt;
      mod_r      <= mod_nxt;
      ovf_r      <= ovf_nxt;
      stop_r     <= stop_nxt;
      pin_r      <= pin_nxt;
      sel_odd_r  <= sel_odd_nxt;
      last_odd_r <= last_odd_nxt;
      prdata     <= prdata_nxt;
      for (int i = 0; i < NUM_CHAN; i++) begin
        ctrl_r[i] <= ctrl_nxt[i];
        cmp_r[i]  <= cmp_nxt[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  // They watch channels 0 to 3, which the bench takes through unbuffered, fixed duty and buffered
  // use; the other channels come from the same generate body.

  a_cmp_sets_flag: assert property (@(posedge mclk) disable iff (!reset_n) // RQ4
    match[0] |=> ctrl_r[0].flag)
    else $error("compare match did not set channel 0 flag");

  a_match_needs_eq: assert property (@(posedge mclk) disable iff (!reset_n) // RQ2
    match[3] |-> (cnt_inc == cmp_r[3]))
    else $error("channel 3 match without counter reaching value");

  a_wrap_to_zero: assert property (@(posedge mclk) disable iff (!reset_n) // RQ21
    wrap |=> (cnt_r == 16'h0000) && ovf_r)
    else $error("overflow did not roll counter to zero");

  a_tov_toggles: assert property (@(posedge mclk) disable iff (!reset_n) // RQ12
    (wrap && ctrl_r[0].tov && !match[0] && !ctrl_r[0].max_duty && ctrl_r[0].mode == MODE_UNBUF)
    |=> (pin_r[0] != $past(pin_r[0])))
    else $error("channel 0 pin did not toggle at overflow");

  a_clear_on_cmp: assert property (@(posedge mclk) disable iff (!reset_n) // RQ13
    (match[0] && ctrl_r[0].action == ACT_CLEAR && !ctrl_r[0].max_duty) |=> !pin_r[0])
    else $error("clear action did not clear channel 0 pin");

  a_full_duty: assert property (@(posedge mclk) disable iff (!reset_n) // RQ22
    (ctrl_r[0].max_duty && !ctrl_r[0].tov && ctrl_r[0].mode == MODE_UNBUF) |=> pin_r[0])
    else $error("max duty did not hold channel 0 high");

  a_odd_released: assert property (@(posedge mclk) disable iff (!reset_n) // RQ8
    buf_pair(ctrl_r[0]) |-> chan_oe_n[1] && !match[1])
    else $error("odd channel active while pair linked");

  a_swap_at_ovf: assert property (@(posedge mclk) disable iff (!reset_n) // RQ7
    (buf_pair(ctrl_r[2]) && !wrap && $past(buf_pair(ctrl_r[2]))) |=> $stable(sel_odd_r[1]))
    else $error("pair selector changed away from overflow");

  a_period_len: assert property (@(posedge mclk) disable iff (!reset_n) // RQ15
    (wrap && mod_r == 16'h00FF && $stable(mod_r)) |-> ##1 (cnt_r == 16'h0000))
    else $error("modulo 255 period did not restart at zero");

  a_unbuf_no_swap: assert property (@(posedge mclk) disable iff (!reset_n) // RQ1
    !buf_pair(ctrl_r[0]) |=> !sel_odd_r[0])
    else $error("unlinked channel 0 not on its own compare value");

  a_idle_no_event: assert property (@(posedge mclk) disable iff (!reset_n) // RQ24
    !run |-> (match == '0) && !wrap)
    else $error("compare or overflow while counter idle");

  a_cmp_reach: assert property (@(posedge mclk) disable iff (!reset_n) // RQ13
    (match[3] && ctrl_r[3].action == ACT_SET) |=> pin_r[3])
    else $error("set action did not set channel 3 pin");

  a_stop_holds: assert property (@(posedge mclk) disable iff (!reset_n) // RQ24
    (!run && !(psel && penable && pwrite)) |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  c_buf_swap:   cover property (@(posedge mclk) disable iff (!reset_n) wrap && last_odd_r[0] && buf_pair(ctrl_r[0]));
  c_pwm_match:  cover property (@(posedge mclk) disable iff (!reset_n) match[0] ##[1:300] wrap);
  c_flag_clash: cover property (@(posedge mclk) disable iff (!reset_n) match[0] && psel && penable && pwrite);
  c_zero_duty:  cover property (@(posedge mclk) disable iff (!reset_n) wrap && !ctrl_r[0].tov && !ctrl_r[0].max_duty);
  c_full_duty:  cover property (@(posedge mclk) disable iff (!reset_n) wrap && !ctrl_r[0].tov && ctrl_r[0].max_duty);

endmodule : tocp_top

`default_nettype wire

// ---- dv/tocp_pin_load.sv ----
// Board load on the channel pins: pulls released pins up and times the pulses.
`timescale 1ns/10ps
`default_nettype none
module tocp_pin_load (
  input  wire logic        mclk,      // Timer clock
  input  wire logic [5:0]  pin_drv,   // Levels the block drives
  input  wire logic [5:0]  pin_oe_n,  // Drive enables, low drives
  input  wire logic [2:0]  sel,       // Pin being timed
  input  wire logic        clr,       // Clears the high-time count
  output logic      [15:0] hi_cnt,    // Cycles high since clear
  output logic      [15:0] width,     // Last high pulse length
  output logic      [15:0] period     // Last rise-to-rise spacing
);
  logic [5:0]  pad;
  logic        prev;
  logic [15:0] run;
  logic [15:0] since;

  // released pin pulled
  // A released pin goes to the pull-up level, so a stale drive value cannot fake a pulse.
  assign pad = pin_drv | pin_oe_n;

  always_ff @(posedge mclk) begin
    prev   <= pad[sel];
    hi_cnt <= clr ? 16'h0000 : hi_cnt + {15'h0000, pad[sel]};
    run    <= pad[sel] ? run + 16'h0001 : 16'h0000;
    since  <= (pad[sel] && !prev) ? 16'h0001 : since + 16'h0001;
    if (!pad[sel] && prev) begin
      width <= run;
    end
    if (pad[sel] && !prev) begin
      period <= since;
    end
  end
endmodule : tocp_pin_load
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the timer output compare and PWM block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tocp_pkg::*;
  logic        mclk;
  logic        reset_n;
  logic        tick_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic [5:0]  chan_out;
  logic [5:0]  chan_oe_n;
  logic [5:0]  cmp_event;
  logic        ovf_event;
  logic [2:0]  sel;
  logic        clr;
  logic [15:0] hi_cnt;
  logic [15:0] width;
  logic [15:0] period;
  logic [31:0] q;
  logic        q_err;
  logic        pslverr;
  int          c;
  int          err_count;
  int          n_checks;

  tocp_top i_tocp_top (.mclk(mclk), .reset_n(reset_n), .tick_en(tick_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_out(chan_out), .chan_oe_n(chan_oe_n), .cmp_event(cmp_event), .ovf_event(ovf_event));
  tocp_pin_load i_tocp_pin_load (.mclk(mclk), .pin_drv(chan_out), .pin_oe_n(chan_oe_n), .sel(sel),
    .clr(clr), .hi_cnt(hi_cnt), .width(width), .period(period));

  always #2.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait on a slave that never answers.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q     = prdata;
    q_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] ctl(input int x);
    ctl = CTRL_BASE + CHAN_STRIDE * 12'(x);
  endfunction : ctl

  function automatic logic [11:0] cmp(input int x);
    cmp = CMP_BASE + CHAN_STRIDE * 12'(x);
  endfunction : cmp

  function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] a, input logic t, input logic mx);
    cw = {26'h0, m, a, t, mx};
  endfunction : cw

  task automatic wait_ovf(output int cmps);
    cmps = 0;
    do begin
      @(negedge mclk);
      if (cmp_event[0] === 1'b1) cmps++;
    end while (ovf_event !== 1'b1);
  endtask : wait_ovf

  // Switching the timed pin fakes an edge in the load, so one whole period after the first
  // overflow restarts its counts; the next period then gives a clean width and spacing.
  task automatic measure(input int ch, input int w);
    @(posedge mclk);
    sel <= 3'(ch);
    wait_ovf(c);
    wait_ovf(c);
    wait_ovf(c);
    chk("pulse width", 32'(w), {16'h0, width});
    chk("pwm period", 32'd256, {16'h0, period});
  endtask : measure

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {mclk, reset_n, psel, penable, pwrite, paddr, pwdata, sel, clr} = '0;
    tick_en = 1'b1;
    err_count = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    apb(0, MOD_OFFS, 0);
    chk("modulo reset", {16'h0, MOD_RESET}, q);
    apb(0, TCTRL_OFFS, 0);
    chk("timer control reset", {24'h0, TCTRL_RESET}, q);
    apb(0, 12'h03C, 0);
    chk("unmapped word", 32'h0, q);
    chk("bus error", 32'h0, {31'h0, q_err});
    $display("test reset done");
    apb(1, MOD_OFFS, 32'h0000_00FF);
    apb(1, cmp(0), 32'd128);
    apb(1, cmp(3), 32'd64);
    apb(1, ctl(0), cw(MODE_UNBUF, ACT_CLEAR, 1'b1, 1'b0));
    apb(1, ctl(3), cw(MODE_UNBUF, ACT_SET, 1'b1, 1'b0));
    apb(1, TCTRL_OFFS, 32'h0);
    measure(0, 128);
    measure(3, 192);
    chk("drive enables", 32'h36, {26'h0, chan_oe_n});
    apb(0, ctl(0), 0);
    chk("compare flag", 32'h1, {31'h0, q[FLD_FLAG]});
    apb(0, TCTRL_OFFS, 0);
    chk("overflow flag", 32'h1, {31'h0, q[FLD_OVF]});
    $display("test unbuffered pwm done");
    @(posedge mclk);
    sel <= 3'd0;
    wait(cmp_event[0] === 1'b1);
    apb(1, cmp(0), 32'd32);
    measure(0, 32);
    wait_ovf(c);
    apb(1, cmp(0), 32'd200);
    measure(0, 200);
    wait_ovf(c);
    chk("compares per period", 32'd1, 32'(c));
    repeat (100) @(posedge mclk);
    apb(1, cmp(0), 32'd50);
    wait_ovf(c);
    chk("compares after passed value", 32'd0, 32'(c));
    $display("test unbuffered update done");
    apb(1, ctl(0), cw(MODE_UNBUF, ACT_CLEAR, 1'b0, 1'b0));
    for (int mx = 0; mx < 2; mx++) begin
      apb(1, ctl(0), cw(MODE_UNBUF, ACT_CLEAR, 1'b0, 1'(mx)));
      wait_ovf(c);
      wait_ovf(c);
      @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      repeat (512) @(posedge mclk);
      @(negedge mclk);
      chk("high cycles", 32'(mx * 512), {16'h0, hi_cnt});
    end
    $display("test fixed duty done");
    // mode 11 on pairs 1 and 2
    for (int p = 0; p < 3; p++) begin
      apb(1, cmp(2 * p + 1), 32'd150);
      apb(1, cmp(2 * p), 32'd64);
      apb(1, ctl(2 * p), cw((p == 0) ? MODE_BUF : 2'h3, ACT_CLEAR, 1'b1, 1'b0));
      measure(2 * p, 64);
      chk("pair enables", 32'h2, {30'h0, chan_oe_n[2*p+1], chan_oe_n[2*p]});
      apb(1, cmp(2 * p + 1), 32'd192);
      measure(2 * p, 192);
      apb(1, cmp(2 * p), 32'd100);
      measure(2 * p, 100);
    end
    $display("test buffered pairs done");
    summarize();
  end

  // The tests need about 13000 cycles; the limit of 50000 cycles allows nearly four times that.
  initial begin
    #250000;
    err_count++;
    summarize();
  end
endmodule : tb
`default_nettype wire
